// *** hdl/rbm_read_buffer.sv ***
// Buffer-read command handler with data and echo buffers
`timescale 1ns/10ps
`default_nettype none

module rbm_read_buffer (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic CMD_VALID,
  input wire logic [4:0] CMD_MODE,
  input wire logic [7:0] CMD_BUF_ID,
  input wire logic [23:0] CMD_OFFSET,
  input wire logic [23:0] CMD_ALLOC_LEN,
  output logic CMD_READY,
  output logic DIN_VALID,
  output logic [7:0] DIN_DATA,
  output logic DIN_LAST,
  input wire logic DIN_READY,
  output logic DONE,
  output logic CHECK_COND,
  output logic [3:0] SENSE_KEY,
  output logic [7:0] SENSE_ASC,
  input wire logic DBUF_WR_EN,
  input wire logic [5:0] DBUF_WR_ADDR,
  input wire logic [7:0] DBUF_WR_DATA,
  input wire logic ECHO_WR_EN,
  input wire logic [4:0] ECHO_WR_ADDR,
  input wire logic [7:0] ECHO_WR_DATA,
  input wire logic ECHO_WR_END,
  input wire logic [5:0] ECHO_WR_LEN
);

  // ==========================================================
  // State
  typedef struct packed {
    rbm_pkg::rbm_state_e state;
    rbm_pkg::rbm_src_e src;
    logic [23:0] idx;
    logic [23:0] remain;
    logic cmd_ready;
    logic done;
    logic check;
    logic [3:0] sense;
    logic [7:0] asc;
    logic v0;
    logic [7:0] d0;
    logic l0;
    logic v1;
    logic [7:0] d1;
    logic l1;
    logic echo_valid;
    logic [5:0] echo_len;
    logic [63:0][7:0] dbuf;
    logic [31:0][7:0] ebuf;
  } rbm_regs_s;

  rbm_regs_s st_ff;
  rbm_regs_s nxt_st;
  logic rst_meta_ff;
  logic rst_sync_ff;
  // Feed of the output buffer in the current cycle
  logic pop;
  logic push;
  logic [7:0] pbyte;
  logic plast;
  logic [23:0] hidx;

  // Smaller of two byte counts
  function automatic logic [23:0] min24(input logic [23:0] a,
                                        input logic [23:0] b);
    min24 = (a < b) ? a : b;
  endfunction

  // Big-endian byte of a 24-bit field; slot 0 is a zero byte
  function automatic logic [7:0] be_byte(input logic [23:0] v,
                                         input logic [1:0] i);
    case (i)
      2'h1: be_byte = v[23:16];
      2'h2: be_byte = v[15:8];
      2'h3: be_byte = v[7:0];
      default: be_byte = 8'h00;
    endcase
  endfunction

  // ==========================================================
  // Reset release
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    pop = st_ff.v0 & DIN_READY;
    push = 1'b0;
    pbyte = 8'h00;
    plast = 1'b0;
    hidx = st_ff.idx - rbm_pkg::HDR_BYTES;

    // Buffers are fed only by the write side; reads never alter them
    if (DBUF_WR_EN) begin
      nxt_st.dbuf[DBUF_WR_ADDR] = DBUF_WR_DATA;
    end
    if (ECHO_WR_EN) begin
      nxt_st.ebuf[ECHO_WR_ADDR] = ECHO_WR_DATA;
    end
    if (ECHO_WR_END) begin
      // Clamped, so an overlong write cannot overstate the contents
      nxt_st.echo_valid = 1'b1;
      nxt_st.echo_len = (ECHO_WR_LEN > rbm_pkg::ECHO_BYTES) ?
                        rbm_pkg::ECHO_BYTES : ECHO_WR_LEN;
    end

    case (st_ff.state)
      rbm_pkg::ST_IDLE: begin
        // Ready is low in the first idle cycle after reset; wait for it
        if (CMD_VALID && st_ff.cmd_ready) begin
          nxt_st.check = 1'b0;
          nxt_st.sense = rbm_pkg::SK_NONE;
          nxt_st.asc = rbm_pkg::ASC_NONE;
          nxt_st.idx = 24'h000000;
          nxt_st.remain = 24'h000000;
          nxt_st.state = rbm_pkg::ST_SEND;
          case (CMD_MODE)
            rbm_pkg::MODE_COMBINED: begin
              // Id and offset are reserved here
              nxt_st.src = rbm_pkg::SRC_HDR;
              nxt_st.remain = min24(CMD_ALLOC_LEN,
                  rbm_pkg::HDR_BYTES + rbm_pkg::DBUF_BYTES);
            end
            rbm_pkg::MODE_DATA: begin
              // Buffer id is not checked; any id reads the data buffer
              nxt_st.src = rbm_pkg::SRC_DATA;
              if (CMD_OFFSET > rbm_pkg::DBUF_BYTES) begin
                nxt_st.check = 1'b1;
                nxt_st.sense = rbm_pkg::SK_ILLEGAL_REQUEST;
                nxt_st.asc = rbm_pkg::ASC_INVALID_FIELD;
                nxt_st.state = rbm_pkg::ST_DRAIN;
              end else begin
                nxt_st.idx = CMD_OFFSET;
                nxt_st.remain = min24(CMD_ALLOC_LEN,
                    rbm_pkg::DBUF_BYTES - CMD_OFFSET);
              end
            end
            rbm_pkg::MODE_DESC: begin
              nxt_st.src = rbm_pkg::SRC_DESC;
              if ((CMD_ALLOC_LEN != 24'h000000) &&
                  (CMD_ALLOC_LEN < rbm_pkg::DESC_BYTES)) begin
                nxt_st.check = 1'b1;
                nxt_st.sense = rbm_pkg::SK_ILLEGAL_REQUEST;
                nxt_st.asc = rbm_pkg::ASC_INVALID_FIELD;
                nxt_st.state = rbm_pkg::ST_DRAIN;
              end else begin
                nxt_st.remain = min24(CMD_ALLOC_LEN,
                                      rbm_pkg::DESC_BYTES);
              end
            end
            rbm_pkg::MODE_ECHO, rbm_pkg::MODE_EXPANDER: begin
              nxt_st.src = rbm_pkg::SRC_ECHO;
              if (!st_ff.echo_valid) begin
                nxt_st.check = 1'b1;
                nxt_st.sense = rbm_pkg::SK_ILLEGAL_REQUEST;
                nxt_st.asc = rbm_pkg::ASC_INVALID_FIELD;
                nxt_st.state = rbm_pkg::ST_DRAIN;
              end else begin
                // Only the low allocation byte counts here
                nxt_st.remain = min24({16'h0000, CMD_ALLOC_LEN[7:0]},
                    {18'h00000, st_ff.echo_len});
              end
            end
            rbm_pkg::MODE_ECHO_DESC: begin
              nxt_st.src = rbm_pkg::SRC_ECHO_DESC;
              nxt_st.remain = min24(CMD_ALLOC_LEN,
                                    rbm_pkg::DESC_BYTES);
            end
            default: begin
              nxt_st.check = 1'b1;
              nxt_st.sense = rbm_pkg::SK_ILLEGAL_REQUEST;
              nxt_st.asc = rbm_pkg::ASC_INVALID_FIELD;
              nxt_st.state = rbm_pkg::ST_DRAIN;
            end
          endcase
          if ((nxt_st.state == rbm_pkg::ST_SEND) &&
              (nxt_st.remain == 24'h000000)) begin
            nxt_st.state = rbm_pkg::ST_DRAIN;
          end
        end
      end

      rbm_pkg::ST_SEND: begin
        // Push only into a free slot; a stalled receiver holds us here
        if (!st_ff.v1) begin
          push = 1'b1;
          plast = (st_ff.remain == 24'h000001);
          case (st_ff.src)
            rbm_pkg::SRC_HDR: begin
              if (st_ff.idx < rbm_pkg::HDR_BYTES) begin
                pbyte = be_byte(rbm_pkg::DBUF_BYTES,
                                st_ff.idx[1:0]);
              end else begin
                pbyte = st_ff.dbuf[hidx[5:0]];
              end
            end
            rbm_pkg::SRC_DATA: begin
              pbyte = st_ff.dbuf[st_ff.idx[5:0]];
            end
            rbm_pkg::SRC_DESC: begin
              if (st_ff.idx[1:0] == 2'h0) begin
                pbyte = rbm_pkg::OFFSET_BOUNDARY;
              end else begin
                pbyte = be_byte(rbm_pkg::DBUF_BYTES,
                                st_ff.idx[1:0]);
              end
            end
            rbm_pkg::SRC_ECHO: begin
              pbyte = st_ff.ebuf[st_ff.idx[4:0]];
            end
            rbm_pkg::SRC_ECHO_DESC: begin
              // Cap fits 16 bits, so slot 1 is zero as well
              pbyte = be_byte(rbm_pkg::ECHO_CAP,
                              st_ff.idx[1:0]);
              if (st_ff.idx[1:0] == 2'h0) begin
                pbyte = {7'h00,
                    rbm_pkg::ECHO_OVERWRITE_SUPPORTED_FLAG};
              end
            end
            default: pbyte = 8'h00;
          endcase
          // Index and count move only when a byte enters the buffer
          nxt_st.idx = st_ff.idx + 24'h000001;
          nxt_st.remain = st_ff.remain - 24'h000001;
          if (plast) begin
            nxt_st.state = rbm_pkg::ST_DRAIN;
          end
        end
      end

      rbm_pkg::ST_DRAIN: begin
        // Status follows the last byte out of the buffer
        if (!st_ff.v0 && !st_ff.v1) begin
          nxt_st.done = 1'b1;
          nxt_st.state = rbm_pkg::ST_IDLE;
        end
      end

      default: nxt_st.state = rbm_pkg::ST_IDLE;
    endcase

    // Two-entry buffer; slot 0 drives the outputs
    // Pop first, so a word pushed now lands behind the older one
    if (pop) begin
      nxt_st.v0 = st_ff.v1;
      nxt_st.d0 = st_ff.d1;
      nxt_st.l0 = st_ff.l1;
      nxt_st.v1 = 1'b0;
    end
    if (push) begin
      if (!nxt_st.v0) begin
        nxt_st.v0 = 1'b1;
        nxt_st.d0 = pbyte;
        nxt_st.l0 = plast;
      end else begin
        nxt_st.v1 = 1'b1;
        nxt_st.d1 = pbyte;
        nxt_st.l1 = plast;
      end
    end
    nxt_st.cmd_ready = (nxt_st.state == rbm_pkg::ST_IDLE);
  end

  // ==========================================================
  // Registers
  // Buffers clear on reset too: costs area, but reads are defined
  always_ff @(posedge REF_CLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Outputs, each a field of the state register
  assign CMD_READY = st_ff.cmd_ready;
  assign DIN_VALID = st_ff.v0;
  assign DIN_DATA = st_ff.d0;
  assign DIN_LAST = st_ff.l0;
  assign DONE = st_ff.done;
  assign CHECK_COND = st_ff.check;
  assign SENSE_KEY = st_ff.sense;
  assign SENSE_ASC = st_ff.asc;

endmodule // rbm_read_buffer

`default_nettype wire

// *** pkg/rbm_pkg.sv ***
// Constants and types for the buffer-read command handler
`default_nettype none

package rbm_pkg;

  // ==========================================================
  // Modes
  localparam logic [4:0] MODE_COMBINED = 5'h00;
  localparam logic [4:0] MODE_DATA = 5'h02;
  localparam logic [4:0] MODE_DESC = 5'h03;
  localparam logic [4:0] MODE_ECHO = 5'h0A;
  localparam logic [4:0] MODE_ECHO_DESC = 5'h0B;
  localparam logic [4:0] MODE_EXPANDER = 5'h1A;

  // ==========================================================
  // Buffer geometry
  localparam logic [23:0] DBUF_BYTES = 24'h000040;
  localparam int DBUF_AW = 6;
  localparam int ECHO_AW = 5;
  localparam logic [5:0] ECHO_BYTES = 6'h20;
  // Capacity rounded down to a four-byte boundary
  localparam logic [23:0] ECHO_CAP = {18'h00000, ECHO_BYTES & 6'h3C};
  localparam logic [23:0] HDR_BYTES = 24'h000004;
  localparam logic [23:0] DESC_BYTES = 24'h000004;
  localparam logic [7:0] OFFSET_BOUNDARY = 8'h09;
  localparam logic ECHO_OVERWRITE_SUPPORTED_FLAG = 1'b0;

  // ==========================================================
  // Status
  localparam logic [3:0] SK_NONE = 4'h0;
  localparam logic [3:0] SK_ILLEGAL_REQUEST = 4'h5;
  localparam logic [7:0] ASC_NONE = 8'h00;
  localparam logic [7:0] ASC_INVALID_FIELD = 8'h24;

  // ==========================================================
  // States and sources
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SEND = 2'h1,
    ST_DRAIN = 2'h2
  } rbm_state_e;

  typedef enum logic [2:0] {
    SRC_HDR = 3'h0,
    SRC_DATA = 3'h1,
    SRC_DESC = 3'h2,
    SRC_ECHO = 3'h3,
    SRC_ECHO_DESC = 3'h4
  } rbm_src_e;

endpackage

`default_nettype wire

// *** verification/rbm_props.sv ***
// Port checker for the buffer-read command handler
`timescale 1ns/10ps
`default_nettype none
module rbm_props (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic CMD_VALID,
  input wire logic [4:0] CMD_MODE,
  input wire logic [23:0] CMD_OFFSET,
  input wire logic [23:0] CMD_ALLOC_LEN,
  input wire logic CMD_READY,
  input wire logic DIN_VALID,
  input wire logic [7:0] DIN_DATA,
  input wire logic DIN_READY,
  input wire logic DONE,
  input wire logic CHECK_COND,
  input wire logic [3:0] SENSE_KEY
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // ==========
  // Helpers
  logic tk;
  logic bad;
  assign tk = CMD_VALID && CMD_READY;
  assign bad = !(CMD_MODE inside {5'h00, 5'h02, 5'h03, 5'h0A, 5'h0B, 5'h1A});
  // ==========
  // Properties
  unsup_check_a: assert property (
    tk && bad |-> ##[2:3] (DONE && CHECK_COND && SENSE_KEY == 4'h5))
    else $error("unsupported mode not refused");
  unsup_nodata_a: assert property (
    tk && bad |=> !DIN_VALID [*3]) else $error("data on bad mode");
  desc_short_a: assert property (
    tk && CMD_MODE == 5'h03 && CMD_ALLOC_LEN inside {[1:3]}
    |-> ##[2:3] (DONE && CHECK_COND)) else $error("short alloc accepted");
  desc_zero_a: assert property (
    tk && CMD_MODE == 5'h03 && CMD_ALLOC_LEN == 24'h0 |=>
    (!DIN_VALID throughout ##[1:2] (DONE && !CHECK_COND)))
    else $error("zero alloc misbehaved");
  raw_offset_a: assert property (
    tk && CMD_MODE == 5'h02 && CMD_OFFSET > 24'h40
    |-> ##[2:3] (DONE && CHECK_COND)) else $error("offset not refused");
  desc_byte0_a: assert property (
    tk && CMD_MODE == 5'h03 && CMD_ALLOC_LEN >= 24'h4
    |-> ##[1:2] (DIN_VALID && DIN_DATA == 8'h09)) else $error("bad exponent");
  stall_hold_a: assert property (
    DIN_VALID && !DIN_READY |=> DIN_VALID && $stable(DIN_DATA))
    else $error("byte lost in stall");
  status_hold_a: assert property (
    !tk |=> $stable(CHECK_COND) && $stable(SENSE_KEY))
    else $error("status changed without command");
  cover property (tk && bad ##[2:3] DONE);
  cover property (DIN_VALID && !DIN_READY);
  cover property (tk && CMD_MODE == 5'h0A ##[1:200] DONE && !CHECK_COND);
endmodule // rbm_props
bind rbm_read_buffer rbm_props i_rbm_props (.REF_CLK(REF_CLK),
  .ARST_N(ARST_N), .CMD_VALID(CMD_VALID), .CMD_MODE(CMD_MODE),
  .CMD_OFFSET(CMD_OFFSET), .CMD_ALLOC_LEN(CMD_ALLOC_LEN),
  .CMD_READY(CMD_READY), .DIN_VALID(DIN_VALID), .DIN_DATA(DIN_DATA),
  .DIN_READY(DIN_READY), .DONE(DONE), .CHECK_COND(CHECK_COND),
  .SENSE_KEY(SENSE_KEY));
`default_nettype wire

// *** verification/rbm_host_model.sv ***
// Initiator-side receiver of the data-in stream
`timescale 1ns/10ps
`default_nettype none
module rbm_host_model (
  input wire logic clk,
  input wire logic clr,
  input wire logic slow,
  input wire logic DIN_VALID,
  input wire logic [7:0] DIN_DATA,
  input wire logic DIN_LAST,
  output logic DIN_READY
);
  // ==========
  // Capture
  logic [7:0] got [0:127];
  int n = 0;
  int last_at = -1;
  logic ph = 1'b0;
  // Stall every other cycle so the buffer must hold its words
  assign DIN_READY = !slow || ph;
  // Ready moves on the falling edge, clear of the sampling edge
  always @(negedge clk) ph <= !ph;
  always @(posedge clk) begin
    if (clr) begin
      n <= 0;
      last_at <= -1;
    end else if (DIN_VALID && DIN_READY) begin
      got[n] <= DIN_DATA;
      n <= n + 1;
      if (DIN_LAST) last_at <= n;
    end
  end
endmodule // rbm_host_model
`default_nettype wire

// *** verification/rbm_read_buffer_tb_top.sv ***
// Self-checking bench of the buffer-read command handler
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((e) !== (g)) begin failures++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module rbm_read_buffer_tb_top;
  logic clk, rst_n, cv, rdy, dv, dl, drdy, dn, cc, dwe, ewe, eend, clr, slow;
  logic [4:0] md, ewa;
  logic [7:0] bid, dd, dwd, ewd, asc;
  logic [23:0] ofs, alen;
  logic [5:0] dwa, elen;
  logic [3:0] sk;
  logic [7:0] ex[$];
  int failures, n_tests;
  rbm_read_buffer i_rbm_read_buffer (.REF_CLK(clk), .ARST_N(rst_n),
    .CMD_VALID(cv), .CMD_MODE(md), .CMD_BUF_ID(bid), .CMD_OFFSET(ofs),
    .CMD_ALLOC_LEN(alen), .CMD_READY(rdy), .DIN_VALID(dv), .DIN_DATA(dd),
    .DIN_LAST(dl), .DIN_READY(drdy), .DONE(dn), .CHECK_COND(cc),
    .SENSE_KEY(sk), .SENSE_ASC(asc), .DBUF_WR_EN(dwe), .DBUF_WR_ADDR(dwa),
    .DBUF_WR_DATA(dwd), .ECHO_WR_EN(ewe), .ECHO_WR_ADDR(ewa),
    .ECHO_WR_DATA(ewd), .ECHO_WR_END(eend), .ECHO_WR_LEN(elen));
  rbm_host_model i_rbm_host_model (.clk(clk), .clr(clr), .slow(slow),
    .DIN_VALID(dv), .DIN_DATA(dd), .DIN_LAST(dl), .DIN_READY(drdy));
  // ==========
  // Helpers
  function automatic logic [7:0] dp(int i); return i[7:0] ^ 8'hA5; endfunction
  function automatic logic [7:0] ep(int i); return i[7:0] ^ 8'h3C; endfunction
  task automatic summarize();
    if (failures == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hang();
    failures++;
    summarize();
  endtask
  // One command, then status and captured bytes against ex
  task automatic run(logic [4:0] m, logic [23:0] o, a, logic ck);
    int i;
    @(negedge clk);
    clr = 1;
    @(negedge clk);
    {clr, md, ofs, alen, cv} = {1'b0, m, o, a, 1'b1};
    for (i = 0; rdy !== 1'b1; i++) begin
      if (i > 50) hang();
      @(negedge clk);
    end
    @(negedge clk);
    cv = 0;
    for (i = 0; dn !== 1'b1; i++) begin
      if (i > 500) hang();
      @(negedge clk);
    end
    `CHK("check", ck, cc)
    `CHK("key", ck ? 4'h5 : 4'h0, sk)
    `CHK("asc", ck ? 8'h24 : 8'h00, asc)
    `CHK("count", ex.size(), i_rbm_host_model.n)
    foreach (ex[k]) `CHK("byte", ex[k], i_rbm_host_model.got[k])
    `CHK("last", ex.size() - 1, i_rbm_host_model.last_at)
    ex = {};
  endtask
  // Both buffers get a known pattern; echo stops at its 32 bytes
  task automatic fill();
    for (int i = 0; i < 64; i++) begin
      @(negedge clk);
      {dwe, dwa, dwd, ewe, ewa, ewd} = {1'b1, i[5:0], dp(i), i < 32,
        i[4:0], ep(i)};
    end
    @(negedge clk);
    {dwe, ewe} = 2'b00;
  endtask
  // ==========
  // Scenarios
  task automatic t_bad();
    logic [4:0] bm[6] = '{5'h01, 5'h04, 5'h09, 5'h0C, 5'h1C, 5'h1F};
    foreach (bm[j]) run(bm[j], 24'h0, 24'h10, 1'b1);
  endtask
  task automatic t_echo();
    run(5'h0A, 24'h0, 24'h8, 1'b1);
    @(negedge clk);
    {eend, elen} = {1'b1, 6'h0A};
    @(negedge clk);
    eend = 0;
    bid = 8'h7E;
    for (int i = 0; i < 5; i++) ex.push_back(ep(i));
    run(5'h0A, 24'h33, 24'h010005, 1'b0);
    for (int i = 0; i < 10; i++) ex.push_back(ep(i));
    run(5'h1A, 24'h0, 24'hFFFF20, 1'b0);
    bid = 8'h00;
    ex = {dp(0), dp(1)};
    run(5'h02, 24'h0, 24'h2, 1'b0);
  endtask
  task automatic t_desc();
    ex = {8'h09, 8'h00, 8'h00, 8'h40};
    run(5'h03, 24'h0, 24'h4, 1'b0);
    run(5'h03, 24'h0, 24'h3, 1'b1);
    run(5'h03, 24'h0, 24'h0, 1'b0);
    ex = {8'h09, 8'h00, 8'h00, 8'h40};
    run(5'h03, 24'h0, 24'h100, 1'b0);
  endtask
  task automatic t_comb();
    slow = 1;
    ex = {8'h00, 8'h00, 8'h00, 8'h40, dp(0), dp(1)};
    run(5'h00, 24'h000200, 24'h6, 1'b0);
    ex = {8'h00, 8'h00, 8'h00, 8'h40};
    for (int i = 0; i < 64; i++) ex.push_back(dp(i));
    run(5'h00, 24'h0, 24'hFFFFFF, 1'b0);
    for (int i = 60; i < 64; i++) ex.push_back(dp(i));
    run(5'h02, 24'h3C, 24'h64, 1'b0);
    slow = 0;
  endtask
  task automatic t_raw();
    ex = {dp(8), dp(9), dp(10)};
    run(5'h02, 24'h8, 24'h3, 1'b0);
    run(5'h02, 24'h41, 24'h10, 1'b1);
    run(5'h02, 24'h40, 24'h10, 1'b0);
    ex = {8'h00, 8'h00, 8'h00, 8'h20};
    run(5'h0B, 24'h0, 24'h8, 1'b0);
    ex = {8'h00, 8'h00};
    run(5'h0B, 24'h0, 24'h2, 1'b0);
  endtask
  // ==========
  // Main sequence
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  initial begin
    {rst_n, cv, dwe, ewe, eend, clr, slow} = '0;
    {md, bid, ofs, alen, dwa, dwd, ewa, ewd, elen} = '0;
    failures = 0;
    n_tests = 0;
    repeat (20) @(negedge clk);
    rst_n = 1;
    // Writes before ready would fall inside the internal reset
    for (int i = 0; rdy !== 1'b1; i++) begin
      if (i > 50) hang();
      @(negedge clk);
    end
    fill();
    t_bad();
    t_echo();
    t_desc();
    t_comb();
    t_raw();
    summarize();
  end
endmodule // rbm_read_buffer_tb_top
`default_nettype wire
